// *** src/region_pkg.sv ***
// Package of address map constants and region codes for the region decoder
package region_pkg;
   // Flash map
   localparam logic [12:0] flash_user_lo = 13'h0000;
   localparam logic [12:0] flash_user_hi = 13'h07FF;
   localparam logic [12:0] flash_lock_lo = 13'h0800;
   localparam logic [12:0] flash_lock_hi = 13'h1FFF;
   localparam int flash_aw = 13;
   localparam int page_aw = 9;
   // Data space map
   localparam int ram_aw = 12;
   localparam logic [11:0] app_lo_lo = 12'h000;
   localparam logic [11:0] app_lo_hi = 12'h07F;
   localparam logic [11:0] eng_lo_lo = 12'h080;
   localparam logic [11:0] eng_lo_hi = 12'h0EF;
   localparam logic [11:0] adv_lo = 12'h0F0;
   localparam logic [11:0] adv_hi = 12'h0FF;
   localparam logic [11:0] shr_lo = 12'h0F0;
   localparam logic [11:0] shr_hi = 12'h10F;
   localparam logic [11:0] app_hi_lo = 12'h110;
   localparam logic [11:0] app_hi_hi = 12'h18F;
   localparam logic [11:0] eng_hi_lo = 12'h190;
   localparam logic [11:0] eng_hi_hi = 12'h3FF;
   localparam logic [11:0] unimp_lo = 12'h400;
   localparam logic [11:0] unimp_hi = 12'hEFF;
   localparam logic [11:0] ctl_lo = 12'hF00;
   localparam logic [11:0] ctl_hi = 12'hFFF;
   // Reset pin release hold, in clock cycles
   localparam logic [3:0] rst_hold_cycles = 4'h4;
   // Region classes of a data space address
   typedef enum logic [2:0] {reg_app, reg_engine, reg_shared, reg_ctl, reg_unimp} ram_region_t;
   // Erase command kinds
   typedef enum logic [1:0] {er_none, er_page, er_mass} erase_kind_t;
endpackage

// *** src/ram_class_if.sv ***
// Interface carrying a data space address and its class
`timescale 1ns/1ps
`default_nettype none
interface ram_class_if;
   import region_pkg::*;
   logic [ram_aw-1:0] addr;
   ram_region_t region;
   logic advanced;
   modport dec (input addr, output region, output advanced);
   modport user (output addr, input region, input advanced);
endinterface
`default_nettype wire

// *** src/ram_classifier.sv ***
// Combinational classifier of data space addresses
`timescale 1ns/1ps
`default_nettype none
module ram_classifier
   import region_pkg::*;
(
   // Address in, class out
   ram_class_if.dec cls
);
   // Range compare of the address against the data space map
   always_comb
   begin
      cls.region = reg_unimp;
      if (cls.addr <= app_lo_hi)
         cls.region = reg_app;
      else if (cls.addr >= eng_lo_lo && cls.addr <= eng_lo_hi)
         cls.region = reg_engine;
      else if (cls.addr >= shr_lo && cls.addr <= shr_hi)
         cls.region = reg_shared;
      else if (cls.addr >= app_hi_lo && cls.addr <= app_hi_hi)
         cls.region = reg_app;
      else if (cls.addr >= eng_hi_lo && cls.addr <= eng_hi_hi)
         cls.region = reg_engine;
      else if (cls.addr >= unimp_lo && cls.addr <= unimp_hi)
         cls.region = reg_unimp;
      else if (cls.addr >= ctl_lo)
         cls.region = reg_ctl;
      cls.advanced = (cls.addr >= adv_lo && cls.addr <= adv_hi);
   end
endmodule
`default_nettype wire

// *** src/memory_region_decoder.sv ***
// Top of the region decoder: flash erase guard, data space class, reset pin
`timescale 1ns/1ps
`default_nettype none
module memory_region_decoder
   import region_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Reset pin, open drain
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   // Other reset causes, active high level
   input wire logic int_rst_req,
   // Core reset output, active low level
   output logic core_rst_n,
   // Erase request from program or debug
   input wire logic erase_req,
   input wire logic erase_from_dbg,
   input wire logic erase_mass,
   input wire logic [flash_aw-1:0] erase_addr,
   // Erase answer
   output logic erase_go,
   output logic [flash_aw-1:0] erase_go_addr,
   output logic [flash_aw-1:0] erase_go_last,
   output logic erase_refused,
   output logic erase_src_dbg,
   // Flash access class
   input wire logic [flash_aw-1:0] flash_addr,
   output logic flash_user,
   output logic flash_locked,
   // Data space access class
   input wire logic [ram_aw-1:0] ram_addr,
   output logic ram_app,
   output logic ram_engine,
   output logic ram_shared,
   output logic ram_advanced,
   output logic ram_ctl,
   output logic ram_unimp,
   output logic app_allowed
);

   // *************************************************
   // State
   // *************************************************
   // Reset sequencer: hold while any cause is active, then count out
   typedef enum logic [1:0] {rs_hold, rs_run} rst_state_t;
   // All state of the block in one record, registered as a whole
   typedef struct packed {
      rst_state_t rst_st;
      logic [3:0] hold_cnt;
      logic pin_drive;
      logic core_rst_n;
      logic erase_go;
      logic [flash_aw-1:0] go_addr;
      logic [flash_aw-1:0] go_last;
      logic erase_refused;
      logic src_dbg;
      logic flash_user;
      logic flash_locked;
      logic ram_app;
      logic ram_engine;
      logic ram_shared;
      logic ram_advanced;
      logic ram_ctl;
      logic ram_unimp;
      logic app_allowed;
   } state_t;
   state_t st_r;
   state_t st_nxt;
   // Link to the data space classifier
   ram_class_if cls ();
   // Helper nets of the next state logic
   logic in_reset;
   logic [flash_aw-1:0] page_base;
   logic [flash_aw-1:0] page_last;

   // *************************************************
   // Data space classifier
   // *************************************************
   // Pure decode; its result is registered with the rest of the state
   ram_classifier u_cls (
      .cls(cls.dec)
   );
   assign cls.addr = ram_addr;

   // *************************************************
   // Erase page bounds and reset causes
   // *************************************************
   // Page bounds of an erase address; a page erase always covers its whole page
   assign page_base = {erase_addr[flash_aw-1:page_aw], {page_aw{1'b0}}};
   assign page_last = {erase_addr[flash_aw-1:page_aw], {page_aw{1'b1}}};
   // Any active cause of reset; the pin sense must show the outside level only
   assign in_reset = !rst_pin_in || int_rst_req;

   // *************************************************
   // Next state
   // *************************************************
   always_comb
   begin
      st_nxt = st_r;
      // Pulses last one cycle; ranges and source hold until the next request
      st_nxt.erase_go = 1'b0;
      st_nxt.erase_refused = 1'b0;

      // Reset sequencing; hold a few cycles after every cause is gone
      case (st_r.rst_st)
         rs_hold:
         begin
            // Count restarts whenever a cause comes back
            if (in_reset)
               st_nxt.hold_cnt = 4'h0;
            else if (st_r.hold_cnt == rst_hold_cycles - 4'h1)
               st_nxt.rst_st = rs_run;
            else
               st_nxt.hold_cnt = st_r.hold_cnt + 4'h1;
         end
         rs_run:
         begin
            // Any cause seen while running starts a new hold
            if (int_rst_req || !rst_pin_in)
            begin
               st_nxt.rst_st = rs_hold;
               st_nxt.hold_cnt = 4'h0;
            end
         end
         default:
         begin
            // Unused code: fall back to holding reset
            st_nxt.rst_st = rs_hold;
            st_nxt.hold_cnt = 4'h0;
         end
      endcase

      // Pin driven low only while internally in reset; pin and core change together
      st_nxt.pin_drive = (st_nxt.rst_st == rs_hold);
      st_nxt.core_rst_n = (st_nxt.rst_st == rs_run);

      // Erase guard, only while out of reset; requests in reset are dropped
      if (erase_req && st_r.rst_st == rs_run)
      begin
         st_nxt.src_dbg = erase_from_dbg;
         // Mass erase is never refused, and it never reaches past the user region
         if (erase_mass)
         begin
            st_nxt.erase_go = 1'b1;
            st_nxt.go_addr = flash_user_lo;
            st_nxt.go_last = flash_user_hi;
         end
         // Locked page: refuse and leave the last range untouched
         else if (erase_addr >= flash_lock_lo && erase_addr <= flash_lock_hi)
            st_nxt.erase_refused = 1'b1;
         else
         begin
            st_nxt.erase_go = 1'b1;
            st_nxt.go_addr = page_base;
            st_nxt.go_last = page_last;
         end
      end

      // Registered access classes
      st_nxt.flash_user = flash_addr <= flash_user_hi;
      st_nxt.flash_locked = flash_addr >= flash_lock_lo;
      st_nxt.ram_app = cls.region == reg_app;
      st_nxt.ram_engine = cls.region == reg_engine;
      st_nxt.ram_shared = cls.region == reg_shared;
      st_nxt.ram_advanced = cls.advanced;
      st_nxt.ram_ctl = cls.region == reg_ctl;
      st_nxt.ram_unimp = cls.region == reg_unimp;
      st_nxt.app_allowed = (cls.region == reg_app) || (cls.region == reg_shared)
         || (cls.region == reg_ctl);
   end

   // *************************************************
   // State register
   // *************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
         st_r.rst_st <= rs_hold;
         st_r.pin_drive <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // *************************************************
   // Outputs
   // *************************************************
   // Reset pin and core reset; the open-drain pin only ever drives low
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = st_r.pin_drive;
   assign core_rst_n = st_r.core_rst_n;

   // Erase answer, straight from flip-flops
   assign erase_go = st_r.erase_go;
   assign erase_go_addr = st_r.go_addr;
   assign erase_go_last = st_r.go_last;
   assign erase_refused = st_r.erase_refused;
   assign erase_src_dbg = st_r.src_dbg;

   // Flash class
   assign flash_user = st_r.flash_user;
   assign flash_locked = st_r.flash_locked;

   // Data space class
   assign ram_app = st_r.ram_app;
   assign ram_engine = st_r.ram_engine;
   assign ram_shared = st_r.ram_shared;
   assign ram_advanced = st_r.ram_advanced;
   assign ram_ctl = st_r.ram_ctl;
   assign ram_unimp = st_r.ram_unimp;
   assign app_allowed = st_r.app_allowed;
endmodule
`default_nettype wire

// *** verification/region_assertions.sv ***
// Checker of the region decoder ports
`timescale 1ns/1ps
`default_nettype none
module region_assertions
   import region_pkg::*;
(
   // Watched ports
   input wire logic clk, nrst, rst_pin_in, rst_pin_out, rst_pin_oe, int_rst_req, core_rst_n,
   input wire logic erase_req, erase_mass, erase_go, erase_refused,
   input wire logic [flash_aw-1:0] erase_addr, erase_go_addr, erase_go_last, flash_addr,
   input wire logic flash_user, flash_locked, ram_app, ram_engine, ram_shared,
   input wire logic ram_advanced, ram_ctl, ram_unimp, app_allowed,
   input wire logic [ram_aw-1:0] ram_addr
);
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic tk;
   // Request taken only outside reset
   assign tk = erase_req && core_rst_n && rst_pin_in && !int_rst_req;
   lock_refuse_a: assert property (tk && !erase_mass && erase_addr > flash_user_hi
      |=> erase_refused && !erase_go) else $error("locked page erase not refused");
   page_go_a: assert property (tk && !erase_mass && erase_addr <= flash_user_hi
      |=> erase_go && erase_go_addr == {$past(erase_addr[12:9]), 9'h000}
      && erase_go_last == {$past(erase_addr[12:9]), 9'h1FF}) else $error("bad page erase");
   mass_user_a: assert property (tk && erase_mass |=> erase_go
      && erase_go_addr == 13'h0000 && erase_go_last == flash_user_hi) else $error("bad mass");
   flash_class_a: assert property (nrst |=> flash_locked == !flash_user
      && flash_user == ($past(flash_addr) <= flash_user_hi)) else $error("bad flash class");
   eng_class_a: assert property (ram_addr inside {[12'h080:12'h0EF], [12'h190:12'h3FF]}
      |=> ram_engine && !ram_app && !app_allowed) else $error("bad engine class");
   app_class_a: assert property (ram_addr inside {[12'h000:12'h07F], [12'h110:12'h18F]}
      |=> ram_app && !ram_engine && app_allowed) else $error("bad app class");
   ctl_class_a: assert property (ram_addr >= 12'hF00 |=> ram_ctl && app_allowed)
      else $error("bad control class");
   unimp_class_a: assert property (ram_addr inside {[12'h400:12'hEFF]}
      |=> ram_unimp && !app_allowed) else $error("bad unimplemented class");
   shared_class_a: assert property (ram_addr inside {[12'h0F0:12'h10F]}
      |=> ram_shared && app_allowed && !ram_engine) else $error("bad shared class");
   adv_area_a: assert property (nrst |=> ram_advanced ==
      ($past(ram_addr) inside {[12'h0F0:12'h0FF]})) else $error("bad advanced flag");
   pin_reset_a: assert property (!rst_pin_in || int_rst_req |=> !core_rst_n && rst_pin_oe)
      else $error("reset cause not obeyed");
   pin_drive_a: assert property (rst_pin_oe == !core_rst_n && !(rst_pin_oe && rst_pin_out))
      else $error("reset pin drive wrong");
   // Main scenarios reached
   cover property (erase_refused);
   cover property (erase_go && erase_go_last == flash_user_hi);
   cover property (ram_advanced);
endmodule
bind memory_region_decoder region_assertions chk (.*);
`default_nettype wire

// *** verification/core_model.sv ***
// Model of the core and debug erase side and of the reset pin wire
`timescale 1ns/1ps
`default_nettype none
module core_model
   import region_pkg::*;
(
   // Clock and reset pin
   input wire logic clk,
   input wire logic ext_low,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   output logic rst_pin_in,
   output logic pin_level,
   // Erase request
   output logic erase_req,
   output logic erase_from_dbg,
   output logic erase_mass,
   output logic [flash_aw-1:0] erase_addr
);
   // ****************
   // Pin and requests
   // ****************
   // Sense sees the outside source only, so a held reset can end
   assign rst_pin_in = !ext_low;
   // Wire level: pull-up unless someone drives low
   assign pin_level = !ext_low && !(rst_pin_oe && !rst_pin_out);
   initial
   begin
      erase_req = 1'b0;
      erase_from_dbg = 1'b0;
      erase_mass = 1'b0;
      erase_addr = 13'h1555;
   end
   // One-cycle request; address scrambled once dropped
   task automatic erase(input logic dbg, input logic mass, input logic [flash_aw-1:0] a);
      @(posedge clk);
      erase_req <= 1'b1;
      erase_from_dbg <= dbg;
      erase_mass <= mass;
      erase_addr <= a;
      @(posedge clk);
      erase_req <= 1'b0;
      erase_addr <= ~a;
   endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Testbench of the region decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import region_pkg::*;
   // ****************
   // Bench
   // ****************
   logic clk = 1'b0, nrst = 1'b0, ext_low = 1'b0, int_rst_req = 1'b0;
   logic rst_pin_in, rst_pin_out, rst_pin_oe, core_rst_n, pin_level, erase_req;
   logic erase_from_dbg, erase_mass, erase_go, erase_refused, erase_src_dbg;
   logic [flash_aw-1:0] erase_addr, erase_go_addr, erase_go_last, flash_addr = 13'h0000;
   logic [ram_aw-1:0] ram_addr = 12'h000;
   logic flash_user, flash_locked, ram_app, ram_engine, ram_shared, ram_advanced;
   logic ram_ctl, ram_unimp, app_allowed;
   logic [11:0] tbl[16] = '{12'h000, 12'h07F, 12'h080, 12'h0EF, 12'h0F0, 12'h0FF, 12'h100,
      12'h10F, 12'h110, 12'h18F, 12'h190, 12'h3FF, 12'h400, 12'hEFF, 12'hF00, 12'hFFF};
   int mismatches = 0;
   int check_count = 0;
   always #25 clk = ~clk;
   memory_region_decoder uut (.*);
   core_model model (.clk, .ext_low, .rst_pin_out, .rst_pin_oe, .rst_pin_in, .pin_level,
      .erase_req, .erase_from_dbg, .erase_mass, .erase_addr);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for the core to leave reset
   task automatic wait_run;
      int n = 0;
      while (core_rst_n !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({n == rst_hold_cycles, rst_pin_oe, pin_level}, 3'b101);
   endtask
   task automatic t_reset;
      wait_run();
      @(posedge clk) ext_low <= 1'b1;
      @(posedge clk) ext_low <= 1'b0;
      #1 chk({core_rst_n, rst_pin_oe, pin_level}, 3'b010);
      wait_run();
      @(posedge clk) int_rst_req <= 1'b1;
      model.erase(1'b0, 1'b0, 13'h0234);
      #1 chk({erase_go, erase_refused, core_rst_n}, 3'b000);
      @(posedge clk) int_rst_req <= 1'b0;
      #1 chk({core_rst_n, rst_pin_oe, pin_level}, 3'b010);
      wait_run();
      $display("reset test done");
   endtask
   task automatic ers(input logic d, input logic m, input logic [12:0] a, input logic [28:0] e);
      model.erase(d, m, a);
      #1 chk({erase_go, erase_refused, erase_src_dbg, erase_go_addr, erase_go_last}, e);
   endtask
   task automatic t_erase;
      ers(1'b0, 1'b0, 13'h0234, {3'b100, 13'h0200, 13'h03FF});
      ers(1'b1, 1'b0, 13'h07FF, {3'b101, 13'h0600, 13'h07FF});
      ers(1'b1, 1'b0, 13'h0800, {3'b011, 13'h0600, 13'h07FF});
      ers(1'b0, 1'b0, 13'h1FFF, {3'b010, 13'h0600, 13'h07FF});
      ers(1'b1, 1'b1, 13'h1234, {3'b101, 13'h0000, 13'h07FF});
      ers(1'b0, 1'b1, 13'h0000, {3'b100, 13'h0000, 13'h07FF});
      $display("erase test done");
   endtask
   function automatic logic [6:0] cls(input logic [11:0] a);
      logic s, p;
      s = a >= 12'h0F0 && a <= 12'h10F;
      p = a <= 12'h07F || (a >= 12'h110 && a <= 12'h18F);
      return {p, !s && !p && a <= 12'h3FF, s, a >= 12'h0F0 && a <= 12'h0FF, a >= 12'hF00,
         a >= 12'h400 && a < 12'hF00, p || s || a >= 12'hF00};
   endfunction
   task automatic t_ram;
      logic [6:0] seen;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         ram_addr <= tbl[i];
         flash_addr <= {tbl[i], 1'b1};
         @(posedge clk);
         #1;
         seen = {ram_app, ram_engine, ram_shared, ram_advanced, ram_ctl, ram_unimp, app_allowed};
         chk(seen, cls(tbl[i]));
         chk({flash_user, flash_locked}, tbl[i] < 12'h400 ? 2'b10 : 2'b01);
      end
      $display("class test done");
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_erase();
      t_ram();
      print_verdict();
   end
   // Watchdog
   initial
   begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
